// file: common/pssd_pkg.sv
// package: constants and types for the port 2 / host soft-strap default loader
package pssd_pkg;
    // =====================================================================
    // strap defaults (value a strap takes when nothing drives it otherwise)
    // =====================================================================
    localparam logic STRAP_SPEED_DFLT    = 1'h1;
    localparam logic STRAP_DUPLEX_DFLT   = 1'h1;
    localparam logic STRAP_P2_BP_DFLT    = 1'h1;
    localparam logic STRAP_P2_PAUSE_DFLT = 1'h1;
    localparam logic STRAP_P2_MAN_DFLT   = 1'h0;
    localparam logic STRAP_H_BP_DFLT     = 1'h1;
    localparam logic STRAP_H_PAUSE_DFLT  = 1'h1;
    localparam logic STRAP_H_MAN_DFLT    = 1'h0;
    localparam logic STRAP_SQE_OFF_DFLT  = 1'h0;

    // =====================================================================
    // advertisement field positions
    // =====================================================================
    localparam int ADV_10HD_BIT  = 5;
    localparam int ADV_10FD_BIT  = 6;
    localparam int ADV_PAUSE_BIT = 10;
    localparam int ADV_W         = 16;
    localparam int MODE_W        = 3;

    // =====================================================================
    // cycle counts
    // =====================================================================
    localparam int LOAD_CYCLES = 2;  // cycles counted after reset release; straps are captured on the next clock

    typedef enum logic [1:0] {
        PSSD_CAPTURE,
        PSSD_RUN
    } pssd_state_t;
endpackage

// file: hw/pssd_strap_defaults.sv
// design: soft-strap default loader for port 2 PHY and host MAC port
//
// Behaviour
// - speed strap sets speed-select low bit
// - speed strap shapes 10M advertisement and mode
// - duplex strap sets PHY duplex bit
// - duplex strap shapes 10M-FD advertisement and mode
// - port 2 backpressure strap sets backpressure enable
// - port 2 pause strap sets tx/rx pause
// - port 2 pause bits act only in manual
// - manual low: follow negotiation, advertise pause
// - manual high: follow pause bits, no advertise
// - host backpressure strap sets host backpressure
// - host pause strap sets host tx/rx pause
// - host manual strap selects manual versus virtual negotiation
// - heartbeat strap sets heartbeat-off bit
// - loader overrides soft straps, pins do not
`timescale 1ns/1ps
module pssd_strap_defaults
    import pssd_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    // strap pins (asynchronous to clk)
    input  wire logic              speed_strap_input,
    input  wire logic              duplex_strap_input,
    input  wire logic              port2_backpressure_default_input,
    input  wire logic              port2_pause_default_input,
    input  wire logic              port2_manual_pause_select_input,
    input  wire logic              host_backpressure_default_input,
    input  wire logic              host_pause_default_input,
    input  wire logic              host_manual_pause_select_input,
    input  wire logic              heartbeat_off_default_input,
    // loader override, same clock
    input  wire logic              loader_valid,
    input  wire logic [8:0]        loader_straps,
    // software writes, same clock
    input  wire logic              sw_port2_pause_wr,
    input  wire logic [2:0]        sw_port2_pause_data,
    input  wire logic              sw_host_pause_wr,
    input  wire logic [2:0]        sw_host_pause_data,
    // negotiation outcomes
    input  wire logic              port2_an_tx_pause,
    input  wire logic              port2_an_rx_pause,
    input  wire logic              host_an_tx_pause,
    input  wire logic              host_an_rx_pause,
    // register defaults and state
    output logic                   defaults_ready,
    output logic                   phy_speed_sel_lsb,
    output logic                   phy_duplex,
    output logic [ADV_W-1:0]       negotiation_advertisement,
    output logic [MODE_W-1:0]      phy_special_mode,
    output logic                   port2_backpressure_enable,
    output logic                   port2_tx_pause_enable,
    output logic                   port2_rx_pause_enable,
    output logic                   port2_manual_pause_select,
    output logic                   host_backpressure_enable,
    output logic                   host_tx_pause_enable,
    output logic                   host_rx_pause_enable,
    output logic                   host_manual_pause_select,
    output logic                   heartbeat_off_bit,
    // effective flow control
    output logic                   port2_tx_pause_active,
    output logic                   port2_rx_pause_active,
    output logic                   host_tx_pause_active,
    output logic                   host_rx_pause_active
);
    // =====================================================================
    // strap synchronisers: three flops, change accepted when 2nd and 3rd agree
    // =====================================================================
    localparam logic [8:0] STRAP_RST = {STRAP_SQE_OFF_DFLT, STRAP_H_MAN_DFLT,
        STRAP_H_PAUSE_DFLT, STRAP_H_BP_DFLT, STRAP_P2_MAN_DFLT,
        STRAP_P2_PAUSE_DFLT, STRAP_P2_BP_DFLT, STRAP_DUPLEX_DFLT,
        STRAP_SPEED_DFLT};

    logic [8:0] pin_raw;
    logic [8:0] s1_q, s2_q, s3_q, filt_q, filt_d;

    assign pin_raw = {heartbeat_off_default_input, host_manual_pause_select_input,
        host_pause_default_input, host_backpressure_default_input,
        port2_manual_pause_select_input, port2_pause_default_input,
        port2_backpressure_default_input, duplex_strap_input, speed_strap_input};

    always_comb begin
        filt_d = filt_q;
        for (int i = 0; i < 9; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                filt_d[i] = s3_q[i];
            end
        end
    end

    // chain has no reset so it tracks the pins while reset is held; the
    // capture edge then sees settled levels. pins must hold three clocks of reset
    always_ff @(posedge clk) begin
        s1_q <= pin_raw;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            filt_q <= STRAP_RST;
        end else begin
            filt_q <= filt_d;
        end
    end

    // =====================================================================
    // capture sequencer
    // =====================================================================
    // straps settle through the synchroniser before the first copy
    pssd_state_t state_q, state_d;
    logic [1:0]  cnt_q, cnt_d;
    logic        load;
    logic [8:0]  src;

    // loader value wins over the pins; pins are only sampled here
    assign src = loader_valid ? loader_straps : filt_q;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        load    = 1'h0;
        case (state_q)
            PSSD_CAPTURE: begin
                if (cnt_q == 2'(LOAD_CYCLES)) begin
                    load    = 1'h1;
                    state_d = PSSD_RUN;
                end else begin
                    cnt_d = cnt_q + 2'h1;
                end
            end
            PSSD_RUN: begin
                load = loader_valid;
            end
            default: state_d = PSSD_CAPTURE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= PSSD_CAPTURE;
            cnt_q   <= 2'h0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    assign defaults_ready = (state_q == PSSD_RUN);

    // =====================================================================
    // default register bits
    // =====================================================================
    logic [12:0] cfg_q, cfg_d;
    logic        spd, dpx;

    assign spd = src[0];
    assign dpx = src[1];

    always_comb begin
        cfg_d = cfg_q;
        if (load) begin
            cfg_d[0]  = spd;
            cfg_d[1]  = dpx;
            cfg_d[2]  = src[2];
            cfg_d[3]  = src[3];
            cfg_d[4]  = src[3];
            cfg_d[5]  = src[4];
            cfg_d[6]  = src[5];
            cfg_d[7]  = src[6];
            cfg_d[8]  = src[6];
            cfg_d[9]  = src[7];
            cfg_d[10] = src[8];
            cfg_d[11] = ~spd;              // 10M half ability
            cfg_d[12] = ~spd & dpx;        // 10M full ability
        end else begin
            if (sw_port2_pause_wr) begin
                cfg_d[5:3] = sw_port2_pause_data;
            end
            if (sw_host_pause_wr) begin
                cfg_d[9:7] = sw_host_pause_data;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= {1'h0, 1'h0, STRAP_SQE_OFF_DFLT, STRAP_H_MAN_DFLT,
                      STRAP_H_PAUSE_DFLT, STRAP_H_PAUSE_DFLT, STRAP_H_BP_DFLT,
                      STRAP_P2_MAN_DFLT, STRAP_P2_PAUSE_DFLT, STRAP_P2_PAUSE_DFLT,
                      STRAP_P2_BP_DFLT, STRAP_DUPLEX_DFLT, STRAP_SPEED_DFLT};
        end else begin
            cfg_q <= cfg_d;
        end
    end

    assign phy_speed_sel_lsb         = cfg_q[0];
    assign phy_duplex                = cfg_q[1];
    assign port2_backpressure_enable = cfg_q[2];
    assign port2_tx_pause_enable     = cfg_q[3];
    assign port2_rx_pause_enable     = cfg_q[4];
    assign port2_manual_pause_select = cfg_q[5];
    assign host_backpressure_enable  = cfg_q[6];
    assign host_tx_pause_enable      = cfg_q[7];
    assign host_rx_pause_enable      = cfg_q[8];
    assign host_manual_pause_select  = cfg_q[9];
    assign heartbeat_off_bit         = cfg_q[10];

    always_comb begin
        negotiation_advertisement                = '0;
        negotiation_advertisement[ADV_10HD_BIT]  = cfg_q[11];
        negotiation_advertisement[ADV_10FD_BIT]  = cfg_q[12];
        negotiation_advertisement[ADV_PAUSE_BIT] = ~cfg_q[5];
    end

    // mode: {speed, duplex, 1} follows forced-mode coding of the PHY
    assign phy_special_mode = {cfg_q[0], cfg_q[1], 1'h1};

    // =====================================================================
    // effective flow control selection
    // =====================================================================
    assign port2_tx_pause_active = cfg_q[5] ? cfg_q[3] : port2_an_tx_pause;
    assign port2_rx_pause_active = cfg_q[5] ? cfg_q[4] : port2_an_rx_pause;
    assign host_tx_pause_active  = cfg_q[9] ? cfg_q[7] : host_an_tx_pause;
    assign host_rx_pause_active  = cfg_q[9] ? cfg_q[8] : host_an_rx_pause;

    // =====================================================================
    // checks
    // =====================================================================
    a_speed_copy: assert property (@(posedge clk) disable iff (!nrst)
        load |=> phy_speed_sel_lsb == $past(src[0]))
        else $error("speed default not copied");
    a_duplex_copy: assert property (@(posedge clk) disable iff (!nrst)
        load |=> phy_duplex == $past(src[1]))
        else $error("duplex default not copied");
    a_adv_tenm: assert property (@(posedge clk) disable iff (!nrst)
        defaults_ready && phy_speed_sel_lsb && !$past(sw_port2_pause_wr)
        |-> negotiation_advertisement[ADV_10HD_BIT] == 1'h0)
        else $error("10M half advertised at 100M");
    a_adv_fd: assert property (@(posedge clk) disable iff (!nrst)
        load && !src[1] |=> !negotiation_advertisement[ADV_10FD_BIT])
        else $error("10M full advertised at half duplex");
    a_p2_bp: assert property (@(posedge clk) disable iff (!nrst)
        load |=> port2_backpressure_enable == $past(src[2]))
        else $error("port 2 backpressure default wrong");
    a_p2_pause: assert property (@(posedge clk) disable iff (!nrst)
        load |=> port2_tx_pause_enable == $past(src[3])
                 && port2_rx_pause_enable == $past(src[3]))
        else $error("port 2 pause default wrong");
    a_p2_select: assert property (@(posedge clk) disable iff (!nrst)
        !port2_manual_pause_select |-> port2_tx_pause_active == port2_an_tx_pause)
        else $error("port 2 pause bits used outside manual");
    a_adv_pause: assert property (@(posedge clk) disable iff (!nrst)
        negotiation_advertisement[ADV_PAUSE_BIT] != port2_manual_pause_select)
        else $error("pause advertisement mismatch");
    a_host_bp: assert property (@(posedge clk) disable iff (!nrst)
        load |=> host_backpressure_enable == $past(src[5]))
        else $error("host backpressure default wrong");
    a_host_pause: assert property (@(posedge clk) disable iff (!nrst)
        load |=> host_tx_pause_enable == $past(src[6]) && host_rx_pause_enable == $past(src[6]))
        else $error("host pause default wrong");
    a_host_sel: assert property (@(posedge clk) disable iff (!nrst)
        host_manual_pause_select |-> host_rx_pause_active == host_rx_pause_enable)
        else $error("host manual selection ignored");
    a_sqe_copy: assert property (@(posedge clk) disable iff (!nrst)
        load |=> heartbeat_off_bit == $past(src[8]))
        else $error("heartbeat default wrong");
    a_ready_time: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> ##[1:4] defaults_ready)
        else $error("defaults not ready in time");
    a_p2_man_copy: assert property (@(posedge clk) disable iff (!nrst)
        load |=> port2_manual_pause_select == $past(src[4]))
        else $error("port 2 manual select default wrong");
    a_host_man_copy: assert property (@(posedge clk) disable iff (!nrst)
        load |=> host_manual_pause_select == $past(src[7]))
        else $error("host manual select default wrong");
    a_adv_half: assert property (@(posedge clk) disable iff (!nrst)
        load |=> negotiation_advertisement[ADV_10HD_BIT] == !$past(src[0]))
        else $error("10M half advertisement default wrong");
    a_mode_copy: assert property (@(posedge clk) disable iff (!nrst)
        load |=> phy_special_mode[2:1] == {$past(src[0]), $past(src[1])})
        else $error("special mode default wrong");

    // =====================================================================
    // checks on software writes and pause selection
    // =====================================================================
    a_p2_sw_write: assert property (@(posedge clk) disable iff (!nrst)
        !load && sw_port2_pause_wr |=> {port2_manual_pause_select, port2_rx_pause_enable,
            port2_tx_pause_enable} == $past(sw_port2_pause_data))
        else $error("port 2 pause write lost");
    a_host_sw_write: assert property (@(posedge clk) disable iff (!nrst)
        !load && sw_host_pause_wr |=> {host_manual_pause_select, host_rx_pause_enable,
            host_tx_pause_enable} == $past(sw_host_pause_data))
        else $error("host pause write lost");
    a_p2_manual_use: assert property (@(posedge clk) disable iff (!nrst)
        port2_manual_pause_select |-> port2_tx_pause_active == port2_tx_pause_enable
                                      && port2_rx_pause_active == port2_rx_pause_enable)
        else $error("port 2 manual pause bits ignored");
    a_p2_rx_auto: assert property (@(posedge clk) disable iff (!nrst)
        !port2_manual_pause_select |-> port2_rx_pause_active == port2_an_rx_pause)
        else $error("port 2 rx pause not negotiated");
    a_host_auto_use: assert property (@(posedge clk) disable iff (!nrst)
        !host_manual_pause_select |-> host_tx_pause_active == host_an_tx_pause
                                      && host_rx_pause_active == host_an_rx_pause)
        else $error("host pause not negotiated");
endmodule // pssd_strap_defaults

// file: verif/pssd_strap_src.sv
// partner model: strap pins and configuration loader feeding the strap default block
`timescale 1ns/1ps
module pssd_strap_src (
    input  wire logic       clk,
    input  wire logic [8:0] pin_val,
    input  wire logic       ld_req,
    input  wire logic [8:0] ld_val,
    output logic [8:0]      pins,
    output logic            ld_valid,
    output logic [8:0]      ld_data
);
    // =====================================================================
    // pins and loader word
    // =====================================================================
    logic [8:0] last_q = 9'h000;

    assign pins = pin_val;
    assign ld_valid = ld_req;
    // idle loader bus shows the inverse of its last word, never a held value
    assign ld_data = ld_req ? ld_val : ~last_q;

    always @(posedge clk) begin
        if (ld_req) begin
            last_q <= ld_val;
        end
    end
endmodule // pssd_strap_src

// file: verif/pssd_strap_defaults_tb_top.sv
// testbench: strap capture, loader override and pause selection of the strap default block
`timescale 1ns/1ps
module pssd_strap_defaults_tb_top;
    import pssd_pkg::*;
    logic        clk, nrst, ld_req, ld_valid, p2_wr, h_wr, rdy;
    logic        spd, dup, p2bp, p2tx, p2rx, p2man, hbp, htx, hrx, hman, hb;
    logic [8:0]  pin_val, ld_val, pins, ld_data;
    logic [2:0]  p2_d, h_d, mode;
    logic [3:0]  an, act;
    logic [15:0] adv;
    logic [29:0] e;
    int          fails, checked, cyc;

    pssd_strap_src src_u (.clk(clk), .pin_val(pin_val), .ld_req(ld_req), .ld_val(ld_val),
        .pins(pins), .ld_valid(ld_valid), .ld_data(ld_data));

    pssd_strap_defaults dut_u (.clk(clk), .nrst(nrst),
        .speed_strap_input(pins[0]), .duplex_strap_input(pins[1]),
        .port2_backpressure_default_input(pins[2]), .port2_pause_default_input(pins[3]),
        .port2_manual_pause_select_input(pins[4]), .host_backpressure_default_input(pins[5]),
        .host_pause_default_input(pins[6]), .host_manual_pause_select_input(pins[7]),
        .heartbeat_off_default_input(pins[8]), .loader_valid(ld_valid),
        .loader_straps(ld_data), .sw_port2_pause_wr(p2_wr), .sw_port2_pause_data(p2_d),
        .sw_host_pause_wr(h_wr), .sw_host_pause_data(h_d), .port2_an_tx_pause(an[3]),
        .port2_an_rx_pause(an[2]), .host_an_tx_pause(an[1]), .host_an_rx_pause(an[0]),
        .defaults_ready(rdy), .phy_speed_sel_lsb(spd), .phy_duplex(dup),
        .negotiation_advertisement(adv), .phy_special_mode(mode),
        .port2_backpressure_enable(p2bp), .port2_tx_pause_enable(p2tx),
        .port2_rx_pause_enable(p2rx), .port2_manual_pause_select(p2man),
        .host_backpressure_enable(hbp), .host_tx_pause_enable(htx),
        .host_rx_pause_enable(hrx), .host_manual_pause_select(hman),
        .heartbeat_off_bit(hb), .port2_tx_pause_active(act[3]),
        .port2_rx_pause_active(act[2]), .host_tx_pause_active(act[1]),
        .host_rx_pause_active(act[0]));

    // =====================================================================
    // expectations
    // =====================================================================
    function automatic logic [29:0] exp_reg(logic [8:0] s);
        logic [15:0] a;
        a = 16'h0000;
        a[ADV_10HD_BIT] = !s[0];
        a[ADV_10FD_BIT] = !s[0] && s[1];
        a[ADV_PAUSE_BIT] = !s[4];
        return {a, s[0], s[1], 1'b1, s[0], s[1], s[2], s[3], s[3], s[4],
                s[5], s[6], s[6], s[7], s[8]};
    endfunction

    function automatic logic [29:0] got();
        return {adv, mode, spd, dup, p2bp, p2tx, p2rx, p2man, hbp, htx, hrx, hman, hb};
    endfunction

    // manual select picks the enable bit, otherwise the negotiated result
    function automatic logic [3:0] exp_act(logic [29:0] v, logic [3:0] n);
        return {v[5] ? v[7] : n[3], v[5] ? v[6] : n[2], v[1] ? v[3] : n[1], v[1] ? v[2] : n[0]};
    endfunction

    task automatic chk_reg(string n, logic [29:0] x, logic [29:0] g);
        checked++;
        if (x !== g) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic chk_act(string n, logic [3:0] x, logic [3:0] g);
        checked++;
        if (x !== g) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic do_reset();
        nrst = 1'b0;
        repeat (5) @(negedge clk);
        chk_reg("reset value", exp_reg(9'h06F), got());
        chk_act("ready in reset", 4'h0, {3'h0, rdy});
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        chk_act("ready early", 4'h0, {3'h0, rdy});
        @(negedge clk);
        chk_act("ready", 4'h1, {3'h0, rdy});
    endtask

    // =====================================================================
    // clock, timeout, sequence
    // =====================================================================
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        nrst = 1'b0;
        ld_req = 1'b0;
        ld_val = 9'h000;
        p2_wr = 1'b0;
        h_wr = 1'b0;
        p2_d = 3'h0;
        h_d = 3'h0;
        an = 4'h0;
        pin_val = 9'h06F;
        void'($urandom(94));
        for (int i = 0; i < 12; i++) begin
            pin_val = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($urandom);
            an = 4'($urandom);
            // corner: a loader word standing at the capture edge replaces the pins
            ld_val = 9'($urandom);
            ld_req = (i == 2);
            do_reset();
            e = exp_reg(ld_req ? ld_val : pin_val);
            chk_reg("strap copy", e, got());
            chk_act("active", exp_act(e, an), act);
            // loader and software write in one cycle: loader must win
            ld_val = 9'($urandom);
            ld_req = 1'b1;
            p2_wr = 1'b1;
            h_wr = 1'b1;
            p2_d = 3'($urandom);
            h_d = 3'($urandom);
            @(negedge clk);
            ld_req = 1'b0;
            p2_wr = 1'b0;
            h_wr = 1'b0;
            @(negedge clk);
            e = exp_reg(ld_val);
            chk_reg("loader copy", e, got());
            p2_wr = 1'b1;
            h_wr = 1'b1;
            for (int k = 0; k < 4; k++) begin
                p2_d = 3'($urandom);
                h_d = 3'($urandom);
                an = 4'($urandom);
                @(negedge clk);
                e[7:5] = {p2_d[0], p2_d[1], p2_d[2]};
                e[3:1] = {h_d[0], h_d[1], h_d[2]};
                // advertised pause follows the port 2 manual bit
                e[MODE_W + 11 + ADV_PAUSE_BIT] = !p2_d[2];
                chk_reg("pause bits", e, got());
                chk_act("active", exp_act(e, an), act);
            end
            p2_wr = 1'b0;
            h_wr = 1'b0;
            // pins are taken only at the capture edge; later changes must not leak
            pin_val = ~pin_val;
            repeat (4) @(negedge clk);
            chk_reg("pins ignored", e, got());
        end
        give_verdict();
    end
endmodule // pssd_strap_defaults_tb_top
